//--- hdl/cwf_pkg.sv
package cwf_pkg;

  // ****************************************
  // Timing figures and clock rate
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int PULSE_MIN_NS = 500;
  localparam int PULSE_MAX_US = 500;
  localparam int WINDOW_MS = 1;
  localparam int TX_STUCK_US = 360;
  localparam int WAKE_PULSES = 3;
  localparam int CNT_W = 17;

  // ****************************************
  // Serial command map
  // ****************************************
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CAN = 3'h1;
  localparam logic [2:0] ADDR_IO = 3'h2;
  localparam logic [2:0] ADDR_INT = 3'h3;
  localparam int CAN_SLEEP_BIT = 0;
  localparam int CAN_WAKE_EN_BIT = 1;
  localparam int INT_STUCK_BIT = 0;
  localparam int INT_HOT_BIT = 1;
  localparam int INT_OC_BIT = 2;
  localparam int INT_AUX_BIT = 3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_STOP,
    MODE_SLEEP
  } cwf_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic [3:0] data;
  } cwf_cmd_t;

  typedef struct packed {
    cwf_mode_t mode;
    logic can_sleep;
    logic wake_en;
    logic [3:0] int_en;
    logic wake_f;
    logic stuck_f;
    logic hot_f;
    logic oc_f;
    logic aux_f;
    logic gen_f;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [3:0] rd;
    logic miso;
    logic [CNT_W-1:0] dom_c;
    logic [CNT_W-1:0] gap_c;
    logic [CNT_W-1:0] win_c;
    logic [CNT_W-1:0] tx_c;
    logic [1:0] pulses;
    logic in_pat;
    logic txs1;
    logic txs2;
    logic wks1;
    logic wks2;
    logic wk_d;
    logic sclk_d;
    logic hot_d;
    logic oc_d;
    logic aux_d;
    logic drv_en;
    logic bus_dom;
    logic rx;
    logic wk_rx_en;
    logic reg_en;
    logic hrst_n;
    logic irq;
  } cwf_state_t;

  localparam cwf_state_t STATE_RST = '{
    mode: MODE_NORMAL,
    txs1: 1'b1,
    txs2: 1'b1,
    rx: 1'b1,
    reg_en: 1'b1,
    default: '0
  };

endpackage

//--- hdl/cwf_monitor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - In transceiver sleep, both line drivers and normal receiver are off.
// - Wake receiver runs in sleep only when wake-up was enabled by command.
// - Returning to normal by command leaves the bus recessive.
// - Sleep with wake-up disabled ignores all bus traffic.
// - Chip sleep wake: main regulator turns on, then host reset releases.
// - Chip stop wake: one pulse on the interrupt output.
// - Normal or standby chip: bus wake sets the wake flag only.
// - Wake flag holds until transceiver normal and status register read.
// - Wake needs three dominant pulses, each over 500 ns, under 500 us.
// - Gaps under 500 us, three pulses inside 1 ms, else pattern rejected.
// - Aux supply low sets its flag, optional interrupt.
// - Main undervoltage feeding aux supply forces reset and sets aux flag.
// - Transmit input low over 360 us disables the driver.
// - Driver comes back as soon as transmit input goes high.
// - Stuck flag at D2 of status, latched, cleared by read after fault.
// - Stuck fault sets general fault flag and optional interrupt.
// - Overheat disables driver, sets overheat and general flags, optional interrupt.
// - Driver returns once the overheat indication clears.
// - Overheat flag held until fault ended and status read.
// - Overcurrent sets latched flag, general flag, optional interrupt.
// - Normal mode: high input recessive, low dominant; receive shows bus.
module cwf_monitor #(
  parameter int PULSE_MAX_CYC = cwf_pkg::PULSE_MAX_US * cwf_pkg::CLK_MHZ,
  parameter int WINDOW_CYC = cwf_pkg::WINDOW_MS * 1000 * cwf_pkg::CLK_MHZ,
  parameter int TX_STUCK_CYC = cwf_pkg::TX_STUCK_US * cwf_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_in,
  input wire logic bus_dom_in,
  input wire logic wake_rx_dom,
  input wire logic local_wake,
  input wire logic driver_hot,
  input wire logic bus_overcurrent,
  input wire logic aux_supply_low,
  input wire logic main_reg_uv,
  input wire logic aux_from_main,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic driver_en,
  output logic bus_drive_dom,
  output logic rx_out,
  output logic wake_rx_en,
  output logic main_reg_en,
  output logic host_rst_n,
  output logic int_out
);

  // ****************************************
  // Cycle counts
  // ****************************************
  localparam int W = cwf_pkg::CNT_W;
  localparam int PMIN = (cwf_pkg::PULSE_MIN_NS * cwf_pkg::CLK_MHZ + 999) / 1000;
  localparam logic [W-1:0] MIN_C = W'(PMIN);
  localparam logic [W-1:0] MAX_C = W'(PULSE_MAX_CYC);
  localparam logic [W-1:0] WIN_C = W'(WINDOW_CYC);
  localparam logic [W-1:0] TXS_C = W'(TX_STUCK_CYC);
  localparam logic [1:0] LAST_P = 2'(cwf_pkg::WAKE_PULSES - 1);

  cwf_pkg::cwf_state_t s;
  cwf_pkg::cwf_state_t n;
  cwf_pkg::cwf_cmd_t cmd;
  logic rd_ev;
  logic wr_ev;
  logic bus_wake;
  logic any_wake;
  logic stuck_act;
  logic stuck_new;
  logic aux_act;
  logic dom;
  logic fell;
  logic valid;

  function automatic logic [3:0] rd_val(input logic [2:0] a,
                                        input cwf_pkg::cwf_state_t st);
    logic [3:0] v;
    v = 4'h0;
    unique case (a)
      cwf_pkg::ADDR_MODE: v = {st.gen_f, 1'b0, st.mode};
      cwf_pkg::ADDR_CAN: v = {st.wake_f, st.stuck_f, st.hot_f, st.oc_f};
      cwf_pkg::ADDR_IO: v = {st.aux_f, 3'h0};
      cwf_pkg::ADDR_INT: v = st.int_en;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  assign stuck_act = !s.txs2 && (s.tx_c == TXS_C);
  assign stuck_new = !s.txs2 && (s.tx_c == TXS_C - W'(1));
  assign aux_act = aux_supply_low | (main_reg_uv & aux_from_main);
  assign dom = s.wks2;
  assign fell = s.wk_d && !s.wks2;
  assign valid = (s.dom_c > MIN_C) && (s.dom_c < MAX_C);

  always_comb begin
    n = s;
    n.irq = 1'b0;
    rd_ev = 1'b0;
    wr_ev = 1'b0;
    bus_wake = 1'b0;
    cmd = {s.sh[6:0], spi_mosi};

    // ****************************************
    // Input synchronisers
    // ****************************************
    n.txs1 = tx_in;
    n.txs2 = s.txs1;
    n.wks1 = wake_rx_dom;
    n.wks2 = s.wks1;
    n.wk_d = s.wks2;
    n.sclk_d = spi_sclk;
    n.hot_d = driver_hot;
    n.oc_d = bus_overcurrent;
    n.aux_d = aux_act;

    // ****************************************
    // Serial command byte
    // ****************************************
    if (spi_cs_n) begin
      n.bitc = 3'h0;
      n.miso = 1'b0;
    end else if (spi_sclk && !s.sclk_d) begin
      n.sh = cmd;
      n.bitc = s.bitc + 3'h1;
      if (s.bitc == 3'h3) begin
        n.rd = rd_val(s.sh[2:0], s);
      end
      if (s.bitc == 3'h7) begin
        wr_ev = cmd.wr;
        rd_ev = !cmd.wr;
      end
    end else if (!spi_sclk && s.sclk_d) begin
      n.miso = s.rd[3];
      n.rd = {s.rd[2:0], 1'b0};
    end

    if (wr_ev) begin
      unique case (cmd.addr)
        cwf_pkg::ADDR_MODE: n.mode = cwf_pkg::cwf_mode_t'(cmd.data[1:0]);
        cwf_pkg::ADDR_CAN: begin
          n.can_sleep = cmd.data[cwf_pkg::CAN_SLEEP_BIT];
          n.wake_en = cmd.data[cwf_pkg::CAN_WAKE_EN_BIT];
        end
        cwf_pkg::ADDR_INT: n.int_en = cmd.data;
        default: n.mode = s.mode;
      endcase
    end

    // ****************************************
    // Read clears, only once the cause is gone
    // ****************************************
    if (rd_ev && cmd.addr == cwf_pkg::ADDR_CAN) begin
      if (!s.can_sleep) n.wake_f = 1'b0;
      if (!stuck_act) n.stuck_f = 1'b0;
      if (!driver_hot) n.hot_f = 1'b0;
      if (!bus_overcurrent) n.oc_f = 1'b0;
    end
    if (rd_ev && cmd.addr == cwf_pkg::ADDR_IO && !aux_act) n.aux_f = 1'b0;
    if (rd_ev && cmd.addr == cwf_pkg::ADDR_MODE) begin
      if (!(stuck_act | driver_hot | bus_overcurrent)) n.gen_f = 1'b0;
    end

    // ****************************************
    // Pattern wake detector
    // ****************************************
    if (!s.wk_rx_en) begin
      n.dom_c = '0;
      n.gap_c = '0;
      n.win_c = '0;
      n.pulses = 2'h0;
      n.in_pat = 1'b0;
    end else begin
      if (s.in_pat) n.win_c = s.win_c + W'(1);
      if (dom) begin
        if (s.dom_c != MAX_C) n.dom_c = s.dom_c + W'(1);
        n.gap_c = '0;
        if (!s.in_pat) begin
          n.in_pat = 1'b1;
          n.win_c = '0;
        end
      end else begin
        n.dom_c = '0;
        if (fell && valid) begin
          n.pulses = s.pulses + 2'h1;
          if (s.pulses == LAST_P) begin
            bus_wake = 1'b1;
            n.pulses = 2'h0;
            n.in_pat = 1'b0;
          end
        end else if (fell) begin
          n.pulses = 2'h0;
          n.in_pat = 1'b0;
        end else if (s.in_pat) begin
          n.gap_c = s.gap_c + W'(1);
          if (s.gap_c >= MAX_C) begin
            n.pulses = 2'h0;
            n.in_pat = 1'b0;
          end
        end
      end
      if (s.in_pat && s.win_c >= WIN_C && !bus_wake) begin
        n.pulses = 2'h0;
        n.in_pat = 1'b0;
      end
    end

    // ****************************************
    // Wake reporting per chip mode
    // ****************************************
    if (bus_wake) n.wake_f = 1'b1;
    any_wake = bus_wake | local_wake;
    if (any_wake && s.mode == cwf_pkg::MODE_SLEEP) begin
      n.mode = cwf_pkg::MODE_NORMAL;
    end
    if (any_wake && s.mode == cwf_pkg::MODE_STOP) begin
      n.mode = cwf_pkg::MODE_NORMAL;
      n.irq = 1'b1;
    end
    n.reg_en = (n.mode != cwf_pkg::MODE_SLEEP);
    n.hrst_n = s.reg_en && !(main_reg_uv && aux_from_main);

    // ****************************************
    // Faults
    // ****************************************
    if (s.txs2) begin
      n.tx_c = '0;
    end else if (s.tx_c != TXS_C) begin
      n.tx_c = s.tx_c + W'(1);
    end
    if (stuck_act) begin
      n.stuck_f = 1'b1;
      n.gen_f = 1'b1;
    end
    if (driver_hot) begin
      n.hot_f = 1'b1;
      n.gen_f = 1'b1;
    end
    if (bus_overcurrent) begin
      n.oc_f = 1'b1;
      n.gen_f = 1'b1;
    end
    if (aux_act) n.aux_f = 1'b1;
    if (stuck_new && s.int_en[cwf_pkg::INT_STUCK_BIT]) n.irq = 1'b1;
    if (driver_hot && !s.hot_d && s.int_en[cwf_pkg::INT_HOT_BIT]) n.irq = 1'b1;
    if (bus_overcurrent && !s.oc_d && s.int_en[cwf_pkg::INT_OC_BIT]) n.irq = 1'b1;
    if (aux_act && !s.aux_d && s.int_en[cwf_pkg::INT_AUX_BIT]) n.irq = 1'b1;

    // ****************************************
    // Line driver and receiver
    // ****************************************
    n.drv_en = !s.can_sleep && !driver_hot && !stuck_act;
    n.bus_dom = n.drv_en && !s.txs2;
    if (s.can_sleep && !n.can_sleep) n.bus_dom = 1'b0;
    n.rx = s.can_sleep ? 1'b1 : !bus_dom_in;
    n.wk_rx_en = s.can_sleep && s.wake_en;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= cwf_pkg::STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign spi_miso = s.miso;
  assign driver_en = s.drv_en;
  assign bus_drive_dom = s.bus_dom;
  assign rx_out = s.rx;
  assign wake_rx_en = s.wk_rx_en;
  assign main_reg_en = s.reg_en;
  assign host_rst_n = s.hrst_n;
  assign int_out = s.irq;

  // ****************************************
  // Checks
  // ****************************************
  a_sleep_drv_off: assert property (@(posedge clk) disable iff (rst)
    s.can_sleep |=> !driver_en && !bus_drive_dom && rx_out)
    else $error("driver active in sleep");
  a_wake_rx_gate: assert property (@(posedge clk) disable iff (rst)
    (s.can_sleep && !s.wake_en) |=> !wake_rx_en)
    else $error("wake receiver on without enable");
  a_no_wake_dis: assert property (@(posedge clk) disable iff (rst)
    !s.wk_rx_en |-> !bus_wake ##1 s.pulses == 2'h0)
    else $error("pattern counted while disabled");
  a_return_rec: assert property (@(posedge clk) disable iff (rst)
    $fell(s.can_sleep) |-> !bus_drive_dom)
    else $error("bus not recessive on return");
  a_sleep_report: assert property (@(posedge clk) disable iff (rst)
    (any_wake && s.mode == cwf_pkg::MODE_SLEEP && !main_reg_en)
      |=> main_reg_en && !host_rst_n ##1 (host_rst_n || $past(main_reg_uv)))
    else $error("sleep wake sequence wrong");
  a_stop_pulse: assert property (@(posedge clk) disable iff (rst)
    (any_wake && s.mode == cwf_pkg::MODE_STOP) |=> int_out ##1 !int_out)
    else $error("stop wake pulse missing");
  a_wake_flag: assert property (@(posedge clk) disable iff (rst)
    bus_wake |=> s.wake_f)
    else $error("wake flag not set");
  a_wake_hold: assert property (@(posedge clk) disable iff (rst)
    (s.wake_f && s.can_sleep) |=> s.wake_f)
    else $error("wake flag lost in sleep");
  a_stuck_off: assert property (@(posedge clk) disable iff (rst)
    stuck_act |=> !driver_en && s.stuck_f && s.gen_f)
    else $error("stuck input not handled");
  a_hot_hold: assert property (@(posedge clk) disable iff (rst)
    (driver_hot && s.hot_f) |=> s.hot_f)
    else $error("overheat flag cleared early");

endmodule

//--- tb/cwf_far_model.sv
`timescale 1ns/1ps
// ****************************************
// Host serial master and bus model
// ****************************************
module cwf_far_model (
  input wire logic clk,
  input wire logic spi_miso,
  input wire logic bus_drive_dom,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic bus_dom_in,
  output logic wake_rx_dom
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    wake_rx_dom = 1'b0;
  end
  // Bus is dominant only while driven
  assign bus_dom_in = bus_drive_dom;
  task automatic xfer(input logic [7:0] b, output logic [3:0] r);
    r = 4'h0;
    @(posedge clk) spi_cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) spi_mosi <= b[i];
      repeat (3) @(posedge clk);
      if (i < 4) r[i] = spi_miso;
      spi_sclk <= 1'b1;
      repeat (3) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (3) @(posedge clk);
    spi_cs_n <= 1'b1;
    // Released line shows inverse of last bit
    spi_mosi <= ~b[0];
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input int w, input int g);
    @(posedge clk) wake_rx_dom <= 1'b1;
    repeat (w) @(posedge clk);
    wake_rx_dom <= 1'b0;
    repeat (g) @(posedge clk);
  endtask
endmodule

//--- tb/cwf_monitor_tb_top.sv
`timescale 1ns/1ps
module cwf_monitor_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tx_in = 1'b1;
  logic driver_hot = 1'b0;
  logic bus_overcurrent = 1'b0;
  logic aux_supply_low = 1'b0;
  logic main_reg_uv = 1'b0;
  logic aux_from_main = 1'b0;
  logic local_wake = 1'b0;
  logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, bus_dom_in, wake_rx_dom;
  logic driver_en, bus_drive_dom, rx_out, wake_rx_en, main_reg_en, host_rst_n, int_out;
  logic [3:0] r;
  int error_cnt = 0;
  int checked = 0;
  int irq_cnt = 0;
  int m_wake = 0;
  int m_stuck = 0;
  int m_hot = 0;
  int m_oc = 0;
  int m_sleep = 0;
  int n;
  always #5 clk = ~clk;
  always @(posedge clk) if (int_out === 1'b1) irq_cnt++;
  cwf_monitor #(.PULSE_MAX_CYC(200), .WINDOW_CYC(400), .TX_STUCK_CYC(100)) dut (
    .clk(clk), .rst(rst), .tx_in(tx_in), .bus_dom_in(bus_dom_in),
    .wake_rx_dom(wake_rx_dom), .local_wake(local_wake), .driver_hot(driver_hot),
    .bus_overcurrent(bus_overcurrent), .aux_supply_low(aux_supply_low),
    .main_reg_uv(main_reg_uv), .aux_from_main(aux_from_main), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .driver_en(driver_en), .bus_drive_dom(bus_drive_dom), .rx_out(rx_out),
    .wake_rx_en(wake_rx_en), .main_reg_en(main_reg_en), .host_rst_n(host_rst_n),
    .int_out(int_out));
  cwf_far_model far (
    .clk(clk), .spi_miso(spi_miso), .bus_drive_dom(bus_drive_dom),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .bus_dom_in(bus_dom_in), .wake_rx_dom(wake_rx_dom));
  // ****************************************
  // Shared tasks and status model
  // ****************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    logic [3:0] q;
    far.xfer({a, 1'b1, d}, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [3:0] e);
    far.xfer({a, 1'b0, 4'h0}, r);
    chk(r, e, "register read");
  endtask
  // Flags clear after a read only if cause is gone
  task automatic rd_can();
    far.xfer({cwf_pkg::ADDR_CAN, 1'b0, 4'h0}, r);
    chk(r, {m_wake[0], m_stuck[0], m_hot[0], m_oc[0]}, "status read");
    if (m_sleep == 0) m_wake = 0;
    if (tx_in) m_stuck = 0;
    if (!driver_hot) m_hot = 0;
    if (!bus_overcurrent) m_oc = 0;
  endtask
  task automatic pulses(input int k);
    repeat (k) far.pulse(60 + $urandom % 30, 20 + $urandom % 30);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(4));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    w(2);
    chk({driver_en, host_rst_n, main_reg_en, int_out}, 4'b1110, "reset outputs");
    @(posedge clk) tx_in <= 1'b0;
    w(8);
    chk({bus_drive_dom, rx_out}, 2'b10, "dominant echo");
    @(posedge clk) tx_in <= 1'b1;
    w(8);
    chk({bus_drive_dom, rx_out}, 2'b01, "recessive echo");
    $display("test echo done");
    wr(cwf_pkg::ADDR_INT, 4'hF);
    n = irq_cnt;
    @(posedge clk) tx_in <= 1'b0;
    m_stuck = 1;
    w(110);
    chk(driver_en, 4'h0, "stuck driver");
    chk(4'(irq_cnt - n), 4'h1, "stuck irq");
    rd_can();
    @(posedge clk) tx_in <= 1'b1;
    w(4);
    chk(driver_en, 4'h1, "driver back");
    rd_can();
    rd_can();
    rd(cwf_pkg::ADDR_MODE, 4'h8);
    $display("test stuck done");
    n = irq_cnt;
    @(posedge clk) driver_hot <= 1'b1;
    m_hot = 1;
    w(4);
    chk(driver_en, 4'h0, "hot driver");
    rd_can();
    @(posedge clk) driver_hot <= 1'b0;
    w(4);
    chk(driver_en, 4'h1, "cool driver");
    rd_can();
    chk(4'(irq_cnt - n), 4'h1, "hot irq");
    @(posedge clk) bus_overcurrent <= 1'b1;
    m_oc = 1;
    w(4);
    @(posedge clk) bus_overcurrent <= 1'b0;
    aux_supply_low <= 1'b1;
    w(4);
    @(posedge clk) aux_supply_low <= 1'b0;
    rd_can();
    rd_can();
    rd(cwf_pkg::ADDR_IO, 4'h8);
    rd(cwf_pkg::ADDR_IO, 4'h0);
    rd(cwf_pkg::ADDR_MODE, 4'h8);
    @(posedge clk) main_reg_uv <= 1'b1;
    aux_from_main <= 1'b1;
    w(3);
    chk(host_rst_n, 4'h0, "uv reset");
    @(posedge clk) main_reg_uv <= 1'b0;
    w(3);
    chk(host_rst_n, 4'h1, "uv release");
    rd(cwf_pkg::ADDR_IO, 4'h8);
    $display("test faults done");
    wr(cwf_pkg::ADDR_CAN, 4'h1);
    m_sleep = 1;
    w(2);
    chk({driver_en, rx_out, wake_rx_en}, 3'b010, "sleep no wake");
    pulses(3);
    rd_can();
    wr(cwf_pkg::ADDR_CAN, 4'h3);
    w(2);
    chk(wake_rx_en, 4'h1, "wake rx on");
    far.pulse(60, 30);
    far.pulse(30, 30);
    pulses(2);
    w(250);
    pulses(2);
    rd_can();
    w(250);
    wr(cwf_pkg::ADDR_MODE, 4'h1);
    pulses(3);
    m_wake = 1;
    rd_can();
    rd(cwf_pkg::ADDR_MODE, 4'h1);
    rd_can();
    wr(cwf_pkg::ADDR_CAN, 4'h0);
    m_sleep = 0;
    w(2);
    chk({driver_en, bus_drive_dom}, 2'b10, "recessive return");
    rd_can();
    rd_can();
    $display("test wake done");
    wr(cwf_pkg::ADDR_MODE, 4'h2);
    wr(cwf_pkg::ADDR_CAN, 4'h3);
    m_sleep = 1;
    n = irq_cnt;
    pulses(3);
    w(10);
    chk(4'(irq_cnt - n), 4'h1, "stop wake irq");
    m_wake = 1;
    wr(cwf_pkg::ADDR_MODE, 4'h2);
    n = irq_cnt;
    @(posedge clk) local_wake <= 1'b1;
    @(posedge clk) local_wake <= 1'b0;
    w(4);
    chk(4'(irq_cnt - n), 4'h1, "local wake irq");
    rd(cwf_pkg::ADDR_MODE, 4'h0);
    rd_can();
    wr(cwf_pkg::ADDR_MODE, 4'h3);
    w(3);
    chk(main_reg_en, 4'h0, "sleep regulator off");
    pulses(3);
    n = 0;
    while (main_reg_en !== 1'b1 && n < 50) begin
      w(1);
      n++;
    end
    w(1);
    chk({main_reg_en, host_rst_n}, 2'b11, "sleep wake");
    wr(cwf_pkg::ADDR_CAN, 4'h0);
    m_sleep = 0;
    rd_can();
    $display("test modes done");
    print_verdict();
  end
endmodule
